// file: bench/pin_source.sv
// external signal source driving the unit pins
`timescale 1ns/1ps
`default_nettype none
module pin_source #(
    parameter real SKEW_NS = 1.3
) (
    input  wire logic [6:0] lvl,
    output logic      [6:0] unit_pin
);
    // ****************
    // pin drive
    // ****************
    // skew keeps edges off the clock edge: the pin is asynchronous
    initial unit_pin = 7'h00;
    always @(lvl) unit_pin <= #(SKEW_NS) lvl;
endmodule
`default_nettype wire

// file: bench/tb_capture_unit_timer_select.sv
// self-checking bench for the capture unit block
`timescale 1ns/1ps
`default_nettype none
module tb_capture_unit_timer_select;
    logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic        awready, wready, bvalid, arready, rvalid, pinmap;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [1:0]  bresp, rresp;
    logic [6:0]  pin_lvl, unit_pin, od, pdir;
    logic [3:0]  strb;
    logic [15:0] t1, t3, t5, t7;
    logic [13:0] tsel, psel;
    logic [27:0] modes;
    logic [31:0] rd_q[$];
    logic [1:0]  resp_q[$];
    int          n_mismatch = 0, check_count = 0, seed = 18, cycles = 0;
    int          n_tab[4] = '{1, 1, 4, 16};
    logic [3:0]  m_tab[4] = '{4'h4, 4'h5, 4'h6, 4'h7};
    // ****************
    // clock, dut, partner
    // ****************
    initial begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end
    capture_unit_timer_select dut (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(strb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .unit_pin(unit_pin),
        .pin_direction_bit(pdir), .timer1(t1), .timer3(t3), .timer5(t5),
        .timer7(t7), .unit_time_base(tsel), .unit_pwm_base(psel),
        .unit_mode_field(modes), .unit_open_drain_bit(od),
        .alternate_pin_map_cfg(pinmap));
    pin_source src (.lvl(pin_lvl), .unit_pin(unit_pin));
    // ****************
    // tasks and monitor
    // ****************
    task automatic cmp_word(input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("[ERR] t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask
    task automatic cmp_resp(input logic [1:0] e, input logic [1:0] g);
        cmp_word({30'h0, e}, {30'h0, g});
    endtask
    task automatic report_and_stop();
        if (n_mismatch == 0 && check_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
        resp_q.push_back(r);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!(bvalid && bready));
        bready <= 1'b0;
        @(posedge aclk);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        rd_q.push_back(e);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!(rvalid && rready));
        rready <= 1'b0;
        @(posedge aclk);
    endtask
    // pulses of three cycles high and low, then time for the synchroniser
    task automatic pulses(input int n);
        repeat (n) begin
            pin_lvl <= 7'h01;
            repeat (3) @(posedge aclk);
            pin_lvl <= 7'h00;
            repeat (3) @(posedge aclk);
        end
        repeat (8) @(posedge aclk);
    endtask
    task automatic restart(input logic [3:0] m);
        wr(capture_pkg::ADDR_CTRL0, 32'h0, 2'h0);
        wr(capture_pkg::ADDR_CTRL0, {28'h0, m}, 2'h0);
        wr(capture_pkg::ADDR_FLAG, 32'h0, 2'h0);
    endtask
    always @(posedge aclk) begin
        cycles++;
        if (rvalid && rready) cmp_word(rd_q.pop_front(), rdata);
        if (bvalid && bready) cmp_resp(resp_q.pop_front(), bresp);
        if (cycles == 20000) begin
            n_mismatch++;
            report_and_stop();
        end
    end
    // ****************
    // main sequence
    // ****************
    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
        {awaddr, araddr, wdata, pin_lvl, t1, t3} = '0;
        strb = 4'hF;
        pdir = 7'h7F;
        t5 = 16'($random(seed));
        t7 = 16'($random(seed));
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        cmp_word(32'h1, {31'h0, pinmap});
        rd(capture_pkg::ADDR_SEL_A, 32'h0);
        wr(capture_pkg::ADDR_SEL_A, 32'hD6, 2'h0);
        rd(capture_pkg::ADDR_SEL_A, 32'hD6);
        cmp_word({28'h0, capture_pkg::TB_T5, capture_pkg::TB_T3},
                 {28'h0, tsel[7:6], tsel[1:0]});
        cmp_word({28'h0, capture_pkg::PB_T8, capture_pkg::PB_T6},
                 {28'h0, psel[7:6], psel[1:0]});
        wr(capture_pkg::ADDR_SEL_B, 32'h16, 2'h0);
        cmp_word({26'h0, {3{capture_pkg::TB_T7}}}, {26'h0, tsel[13:8]});
        cmp_word({26'h0, capture_pkg::PB_T2, capture_pkg::PB_T4, capture_pkg::PB_T6},
                 {26'h0, psel[13:8]});
        wr(capture_pkg::ADDR_OD, 32'hFC, 2'h0);
        cmp_word(32'h7E, {25'h0, od});
        wr(12'hFFC, 32'h1, capture_pkg::RESP_SLVERR);
        wr(capture_pkg::ADDR_SEL_A, 32'h0, 2'h0);
        strb <= 4'hE;
        wr(capture_pkg::ADDR_SEL_A, 32'hD7, 2'h0);
        rd(capture_pkg::ADDR_SEL_A, 32'h0);
        strb <= 4'hF;
        for (int i = 0; i < 4; i++) begin
            restart(m_tab[i]);
            cmp_word({28'h0, m_tab[i]}, {28'h0, modes[3:0]});
            t1 <= 16'($random(seed));
            pulses(n_tab[i] - 1);
            rd(capture_pkg::ADDR_FLAG, 32'h0);
            pulses(1);
            rd(capture_pkg::ADDR_FLAG, 32'h2);
            rd(capture_pkg::ADDR_VALUE0, {16'h0, t1});
        end
        wr(capture_pkg::ADDR_SEL_A, 32'h1, 2'h0);
        restart(capture_pkg::MODE_RISE);
        t3 <= 16'($random(seed));
        pulses(1);
        t3 <= 16'($random(seed));
        pulses(1);
        rd(capture_pkg::ADDR_VALUE0, {16'h0, t3});
        rd(capture_pkg::ADDR_FLAG, 32'h2);
        pdir <= 7'h7E;
        restart(capture_pkg::MODE_RISE);
        t3 <= 16'($random(seed));
        wr(capture_pkg::ADDR_PORTWR, 32'h1, 2'h0);
        repeat (8) @(posedge aclk);
        rd(capture_pkg::ADDR_VALUE0, {16'h0, t3});
        report_and_stop();
    end
endmodule
`default_nettype wire

// file: rtl/capture_pkg.sv
// constants shared by the capture unit block
// ****************************************************
// ****************************************************
package capture_pkg;
    localparam int          NUM_UNITS     = 7;
    localparam logic [11:0] ADDR_CTRL0    = 12'h000;
    localparam logic [11:0] ADDR_VALUE0   = 12'h020;
    localparam logic [11:0] ADDR_SEL_A    = 12'h040;
    localparam logic [11:0] ADDR_SEL_B    = 12'h044;
    localparam logic [11:0] ADDR_OD       = 12'h048;
    localparam logic [11:0] ADDR_FLAG     = 12'h04C;
    localparam logic [11:0] ADDR_ENABLE   = 12'h050;
    localparam logic [11:0] ADDR_PORTWR   = 12'h054;
    localparam logic [11:0] ADDR_CFG      = 12'h058;
    localparam logic [7:0]  SEL_A_MASK    = 8'hD7;
    localparam logic [7:0]  SEL_B_MASK    = 8'h17;
    localparam logic [7:0]  SEL_B_SMALL   = 8'h03;
    localparam logic [7:0]  OD_MASK       = 8'hFC;
    localparam int          OD_LSB        = 2;
    localparam int          FLAG_LSB      = 1;
    localparam int          PINMAP_BIT    = 1;
    localparam logic [7:0]  CFG_RESET     = 8'h02;
    localparam logic [3:0]  MODE_OFF      = 4'h0;
    localparam logic [3:0]  MODE_FALL     = 4'h4;
    localparam logic [3:0]  MODE_RISE     = 4'h5;
    localparam logic [3:0]  MODE_RISE4    = 4'h6;
    localparam logic [3:0]  MODE_RISE16   = 4'h7;
    localparam logic [3:0]  PRESC_DIV4    = 4'h3;
    localparam logic [3:0]  PRESC_DIV16   = 4'hF;
    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;
    // timer index: 0=timer1 .. 3=timer7
    localparam logic [1:0]  TB_T1         = 2'h0;
    localparam logic [1:0]  TB_T3         = 2'h1;
    localparam logic [1:0]  TB_T5         = 2'h2;
    localparam logic [1:0]  TB_T7         = 2'h3;
    // pwm timer index: 0=timer2 .. 3=timer8
    localparam logic [1:0]  PB_T2         = 2'h0;
    localparam logic [1:0]  PB_T4         = 2'h1;
    localparam logic [1:0]  PB_T6         = 2'h2;
    localparam logic [1:0]  PB_T8         = 2'h3;
endpackage

// file: rtl/capture_unit_timer_select.sv
// capture units 4-10 with time base selection, open-drain and pin mapping
`timescale 1ns/1ps
`default_nettype none
module capture_unit_timer_select #(
    parameter bit SMALL_VARIANT = 1'b0
) (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic      [1:0]  s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic      [31:0] s_axi_rdata,
    output logic      [1:0]  s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic [6:0]  unit_pin,
    input  wire logic [6:0]  pin_direction_bit,
    input  wire logic [15:0] timer1,
    input  wire logic [15:0] timer3,
    input  wire logic [15:0] timer5,
    input  wire logic [15:0] timer7,
    output logic      [13:0] unit_time_base,
    output logic      [13:0] unit_pwm_base,
    output logic      [27:0] unit_mode_field,
    output logic      [6:0]  unit_open_drain_bit,
    output logic             alternate_pin_map_cfg
);
    // ****************************************************
    // state
    // ****************************************************
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b00,
        BUS_RESP = 2'b01
    } bus_e;

    typedef struct packed {
        bus_e        wst;
        bus_e        rst;
        logic        have_aw;
        logic        have_w;
        logic [11:0] waddr;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        awready;
        logic        wready;
        logic        arready;
        logic [1:0]  bresp;
        logic        rpend;
        logic [11:0] raddr;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        logic [27:0] mode;
        logic [7:0]  sel_a;
        logic [7:0]  sel_b;
        logic [7:0]  od;
        logic [7:0]  cfg;
        logic [6:0]  flag;
        logic [6:0]  enable;
        logic [6:0]  s1;
        logic [6:0]  s2;
        logic [6:0]  s3;
        logic [6:0]  pin_prev;
        logic [27:0] presc;
        logic [13:0] tbase;
        logic [13:0] pbase;
    } state_s;

    state_s       st;
    state_s       next_st;
    logic [6:0]   cap_wr;
    logic [111:0] cap_data;
    logic [2:0]   mem_raddr;
    logic [15:0]  mem_rdata;

    function automatic logic is_capture(input logic [3:0] m);
        is_capture = (m == capture_pkg::MODE_FALL) || (m == capture_pkg::MODE_RISE) ||
                     (m == capture_pkg::MODE_RISE4) || (m == capture_pkg::MODE_RISE16);
    endfunction

    function automatic logic [15:0] timer_of(input logic [1:0] t, input logic [15:0] a,
        input logic [15:0] b, input logic [15:0] c, input logic [15:0] d);
        case (t)
            capture_pkg::TB_T1: timer_of = a;
            capture_pkg::TB_T3: timer_of = b;
            capture_pkg::TB_T5: timer_of = c;
            default:            timer_of = d;
        endcase
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
        input logic [3:0] strb);
        merge = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                merge[8*b +: 8] = nw[8*b +: 8];
            end
        end
    endfunction

    capture_value_mem u_mem (
        .aclk    (aclk),
        .aresetn (aresetn),
        .wr_en   ({1'b0, cap_wr}),
        .wr_data ({16'h0000, cap_data}),
        .rd_addr (mem_raddr),
        .rd_data (mem_rdata)
    );

    // ****************************************************
    // next state
    // ****************************************************
    always_comb begin
        logic [31:0] wv;
        logic [3:0]  m;
        logic        rise;
        logic        fall;
        logic        ev;
        logic        hit;
        logic [1:0]  c;
        logic        wr_go;
        logic [6:0]  clr;
        wv       = 32'h0000_0000;
        m        = 4'h0;
        rise     = 1'b0;
        fall     = 1'b0;
        ev       = 1'b0;
        hit      = 1'b0;
        c        = 2'h0;
        wr_go    = 1'b0;
        clr      = 7'h00;
        next_st  = st;
        cap_wr   = 7'h00;
        cap_data = '0;
        mem_raddr = 3'h0;

        // write channel: address and data in either order
        next_st.awready = 1'b0;
        next_st.wready  = 1'b0;
        if (s_axi_awvalid && st.awready) begin
            next_st.have_aw = 1'b1;
            next_st.waddr   = s_axi_awaddr;
        end
        if (s_axi_wvalid && st.wready) begin
            next_st.have_w = 1'b1;
            next_st.wdata  = s_axi_wdata;
            next_st.wstrb  = s_axi_wstrb;
        end
        if (st.wst == BUS_IDLE) begin
            next_st.awready = !next_st.have_aw && !(s_axi_awvalid && st.awready);
            next_st.wready  = !next_st.have_w && !(s_axi_wvalid && st.wready);
            wr_go = st.have_aw && st.have_w;
        end else if (s_axi_bready) begin
            next_st.wst = BUS_IDLE;
        end

        if (wr_go) begin
            next_st.wst     = BUS_RESP;
            next_st.have_aw = 1'b0;
            next_st.have_w  = 1'b0;
            next_st.bresp   = capture_pkg::RESP_OKAY;
            wv = merge(32'h0000_0000, st.wdata, st.wstrb);
            if (!st.wstrb[0]) begin
                // every register sits in lane zero: with it off nothing is stored
            end else if (st.waddr[11:5] == capture_pkg::ADDR_CTRL0[11:5] &&
                         st.waddr[4:2] < 3'd7) begin
                // mode change may flag a stale edge; switching keeps the count
                next_st.mode[4*st.waddr[4:2] +: 4] = wv[3:0];
            end else begin
                case (st.waddr)
                    capture_pkg::ADDR_SEL_A:  next_st.sel_a = wv[7:0] &
                        capture_pkg::SEL_A_MASK;
                    capture_pkg::ADDR_SEL_B:  next_st.sel_b = wv[7:0] &
                        (SMALL_VARIANT ? capture_pkg::SEL_B_SMALL : capture_pkg::SEL_B_MASK);
                    capture_pkg::ADDR_OD:     next_st.od = wv[7:0] & capture_pkg::OD_MASK;
                    capture_pkg::ADDR_FLAG:   clr = ~wv[7:1];
                    capture_pkg::ADDR_ENABLE: next_st.enable = wv[7:1];
                    capture_pkg::ADDR_PORTWR: ;
                    capture_pkg::ADDR_CFG:    next_st.cfg = wv[7:0] & capture_pkg::CFG_RESET;
                    default:                  next_st.bresp = capture_pkg::RESP_SLVERR;
                endcase
            end
        end

        // read channel; value reads pass through the memory register
        next_st.arready = 1'b0;
        if (st.rst == BUS_IDLE) begin
            if (st.rpend) begin
                next_st.rpend = 1'b0;
                next_st.rst   = BUS_RESP;
                next_st.rresp = capture_pkg::RESP_OKAY;
                next_st.rdata = 32'h0000_0000;
                if (st.raddr[11:5] == capture_pkg::ADDR_VALUE0[11:5] && st.raddr[4:2] < 3'd7) begin
                    next_st.rdata = {16'h0000, mem_rdata};
                end else if (st.raddr[11:5] == capture_pkg::ADDR_CTRL0[11:5] &&
                             st.raddr[4:2] < 3'd7) begin
                    next_st.rdata = {28'h0, st.mode[4*st.raddr[4:2] +: 4]};
                end else begin
                    case (st.raddr)
                        capture_pkg::ADDR_SEL_A:  next_st.rdata = {24'h0, st.sel_a};
                        capture_pkg::ADDR_SEL_B:  next_st.rdata = {24'h0, st.sel_b};
                        capture_pkg::ADDR_OD:     next_st.rdata = {24'h0, st.od};
                        capture_pkg::ADDR_FLAG:   next_st.rdata = {24'h0, st.flag, 1'b0};
                        capture_pkg::ADDR_ENABLE: next_st.rdata = {24'h0, st.enable, 1'b0};
                        capture_pkg::ADDR_PORTWR: ;
                        capture_pkg::ADDR_CFG:    next_st.rdata = {24'h0, st.cfg};
                        default:                  next_st.rresp = capture_pkg::RESP_SLVERR;
                    endcase
                end
            end else if (s_axi_arvalid && st.arready) begin
                next_st.rpend = 1'b1;
                next_st.raddr = s_axi_araddr;
            end else begin
                next_st.arready = !s_axi_arvalid || !st.arready;
            end
        end else if (s_axi_rready) begin
            next_st.rst = BUS_IDLE;
        end
        mem_raddr = next_st.raddr[4:2];

        // pin synchroniser: three stages, change counts when stages two and three agree
        next_st.s1 = unit_pin;
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
        if (st.s2 == st.s3) begin
            next_st.pin_prev = st.s3;
        end

        // time base decode per unit
        next_st.tbase = '0;
        next_st.pbase = '0;
        c = st.sel_a[1:0];
        next_st.tbase[1:0] = (c == 2'h0) ? capture_pkg::TB_T1 : capture_pkg::TB_T3;
        next_st.pbase[1:0] = (c == 2'h2) ? capture_pkg::PB_T6 :
                             (c == 2'h1) ? capture_pkg::PB_T4 : capture_pkg::PB_T2;
        next_st.tbase[3:2] = st.sel_a[2] ? capture_pkg::TB_T5 : capture_pkg::TB_T1;
        next_st.pbase[3:2] = st.sel_a[2] ? capture_pkg::PB_T4 : capture_pkg::PB_T2;
        next_st.tbase[5:4] = st.sel_a[4] ? capture_pkg::TB_T5 : capture_pkg::TB_T1;
        next_st.pbase[5:4] = capture_pkg::PB_T2;
        c = st.sel_a[7:6];
        next_st.tbase[7:6] = (c == 2'h0) ? capture_pkg::TB_T1 : capture_pkg::TB_T5;
        next_st.pbase[7:6] = c;
        c = st.sel_b[1:0];
        next_st.tbase[9:8] = (c == 2'h0 || SMALL_VARIANT) ? capture_pkg::TB_T1 :
                             capture_pkg::TB_T7;
        next_st.pbase[9:8] = (c == 2'h2) ? capture_pkg::PB_T6 :
                             (c == 2'h1) ? capture_pkg::PB_T4 : capture_pkg::PB_T2;
        next_st.tbase[11:10] = st.sel_b[2] ? capture_pkg::TB_T7 : capture_pkg::TB_T1;
        next_st.pbase[11:10] = st.sel_b[2] ? capture_pkg::PB_T4 : capture_pkg::PB_T2;
        next_st.tbase[13:12] = st.sel_b[4] ? capture_pkg::TB_T7 : capture_pkg::TB_T1;
        next_st.pbase[13:12] = capture_pkg::PB_T2;

        // capture engines, one per unit
        for (int u = 0; u < capture_pkg::NUM_UNITS; u++) begin
            m    = st.mode[4*u +: 4];
            rise = (st.s2[u] == st.s3[u]) && st.s3[u] && !st.pin_prev[u];
            fall = (st.s2[u] == st.s3[u]) && !st.s3[u] && st.pin_prev[u];
            ev   = 1'b0;
            hit  = 1'b0;
            if (SMALL_VARIANT && u >= 5) begin
                m = capture_pkg::MODE_OFF;
            end
            // unit 4 driven as output: software port write is itself the event
            if (u == 0 && !pin_direction_bit[0] && wr_go &&
                st.waddr == capture_pkg::ADDR_PORTWR) begin
                ev = 1'b1;
            end
            if (!is_capture(m)) begin
                next_st.presc[4*u +: 4] = 4'h0;
            end else begin
                case (m)
                    capture_pkg::MODE_FALL: hit = fall || ev;
                    capture_pkg::MODE_RISE: hit = rise || ev;
                    default: begin
                        if (rise || ev) begin
                            if (st.presc[4*u +: 4] ==
                                ((m == capture_pkg::MODE_RISE4) ? capture_pkg::PRESC_DIV4 :
                                 capture_pkg::PRESC_DIV16) ||
                                (m == capture_pkg::MODE_RISE4 &&
                                 st.presc[4*u+2 +: 2] != 2'h0)) begin
                                next_st.presc[4*u +: 4] = 4'h0;
                                hit = 1'b1;
                            end else begin
                                next_st.presc[4*u +: 4] = st.presc[4*u +: 4] + 4'h1;
                            end
                        end
                    end
                endcase
            end
            if (hit) begin
                // newest value wins with no overrun mark
                cap_wr[u]            = 1'b1;
                cap_data[16*u +: 16] = timer_of(st.tbase[2*u +: 2], timer1, timer3, timer5,
                                                timer7);
            end
            // set beats the software clear
            next_st.flag[u] = hit | (st.flag[u] & ~clr[u]);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st       <= '0;
            st.cfg   <= capture_pkg::CFG_RESET;
            st.s1    <= '0;
        end else begin
            st <= next_st;
        end
    end

    // ****************************************************
    // outputs
    // ****************************************************
    assign s_axi_awready         = st.awready;
    assign s_axi_wready          = st.wready;
    // response is the only bus state with bit 0 set
    assign s_axi_bvalid          = st.wst[0];
    assign s_axi_bresp           = st.bresp;
    assign s_axi_arready         = st.arready;
    assign s_axi_rvalid          = st.rst[0];
    assign s_axi_rdata           = st.rdata;
    assign s_axi_rresp           = st.rresp;
    assign unit_time_base        = st.tbase;
    assign unit_pwm_base         = st.pbase;
    assign unit_mode_field       = st.mode;
    assign unit_open_drain_bit   = st.od[7:1];
    assign alternate_pin_map_cfg = st.cfg[capture_pkg::PINMAP_BIT];

    // ****************************************************
    // checks
    // ****************************************************
    logic wr_go_q;
    assign wr_go_q = (st.wst == BUS_IDLE) && st.have_aw && st.have_w;

    a_off_clears_presc: assert property (@(posedge aclk) disable iff (!aresetn)
        (st.mode[3:0] == capture_pkg::MODE_OFF) |=> (st.presc[3:0] == 4'h0))
        else $error("prescaler not cleared when off");
    a_flag_sticky: assert property (@(posedge aclk) disable iff (!aresetn)
        (st.flag[0] && !(wr_go_q && st.waddr == capture_pkg::ADDR_FLAG)) |=> st.flag[0])
        else $error("flag dropped without software clear");
    a_rise_capture: assert property (@(posedge aclk) disable iff (!aresetn)
        (st.mode[3:0] == capture_pkg::MODE_RISE && $past(st.mode[3:0]) == capture_pkg::MODE_RISE
         && st.s2[0] == st.s3[0] && st.s3[0] && !st.pin_prev[0]) |=> st.flag[0])
        else $error("rising edge did not capture");
    a_rsel_mask: assert property (@(posedge aclk) disable iff (!aresetn)
        ((st.sel_a & ~capture_pkg::SEL_A_MASK) == 8'h00) &&
        ((st.sel_b & ~capture_pkg::SEL_B_MASK) == 8'h00))
        else $error("unimplemented select bits set");
    a_base_zero: assert property (@(posedge aclk) disable iff (!aresetn)
        ($past(st.sel_a[1:0]) == 2'h0 && $past(aresetn)) |-> (st.tbase[1:0] == capture_pkg::TB_T1))
        else $error("unit 4 code zero not timer1");
    a_unit7_base: assert property (@(posedge aclk) disable iff (!aresetn)
        ($past(st.sel_a[7:6]) == 2'h3 && $past(aresetn)) |-> (st.pbase[7:6] == capture_pkg::PB_T8))
        else $error("unit 7 code three not timer8");
    a_cap_write: assert property (@(posedge aclk) disable iff (!aresetn)
        (cap_wr != 7'h00) |=> ((st.flag & $past(cap_wr)) == $past(cap_wr)))
        else $error("capture without flag");
    a_od_bits: assert property (@(posedge aclk) disable iff (!aresetn)
        unit_open_drain_bit[0] == 1'b0)
        else $error("open-drain bit outside field");
endmodule
`default_nettype wire

// file: rtl/capture_value_mem.sv
// small memory holding the captured value of each unit
`timescale 1ns/1ps
`default_nettype none
module capture_value_mem (
    input  wire logic         aclk,
    input  wire logic         aresetn,
    input  wire logic [7:0]   wr_en,
    input  wire logic [127:0] wr_data,
    input  wire logic [2:0]   rd_addr,
    output logic      [15:0]  rd_data
);
    logic [15:0] mem [0:7];

    // one write lane per word: captures on several pins in one cycle all land
    always_ff @(posedge aclk) begin
        for (int i = 0; i < 8; i++) begin
            if (wr_en[i]) begin
                mem[i] <= wr_data[16*i +: 16];
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rd_data <= 16'h0000;
        end else begin
            rd_data <= mem[rd_addr];
        end
    end
endmodule
`default_nettype wire
